// ---- src/phy_ctrl_pkg.sv ----
`default_nettype none
package phy_ctrl_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Management register space
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_STD_LAST      = 5'h0F;
    localparam logic [4:0] REG_VENDOR_FIRST  = 5'h10;
    localparam logic [4:0] REG_VENDOR_LAST   = 5'h1F;
    localparam int         REG_COUNT         = 32;

    // Field positions in the basic control register
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_LOOPBACK   = 14;
    localparam int BIT_SPEED_SEL  = 13;
    localparam int BIT_AN_ENABLE  = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE    = 10;
    localparam int BIT_AN_RESTART = 9;

    // Values after reset for the bits not taken from straps
    localparam logic RST_LOOPBACK   = 1'b0;
    localparam logic RST_POWER_DOWN = 1'b0;
    localparam logic RST_AN_RESTART = 1'b0;
    localparam logic RST_SOFT_RESET = 1'b0;

    // Strap vector order and settle count after reset release
    localparam int         STRAP_SPEED   = 0;
    localparam int         STRAP_AN      = 1;
    localparam int         STRAP_ISOLATE = 2;
    localparam int         STRAP_COUNT   = 3;
    localparam logic [1:0] STRAP_SETTLE  = 2'h3;

    // Serial management frame
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [1:0] OP_READ      = 2'h2;
    localparam logic [1:0] OP_WRITE     = 2'h1;
    localparam logic [5:0] HDR_LAST     = 6'h0B;
    localparam logic [5:0] DATA_LAST    = 6'h0F;

    typedef struct packed {
        logic        write;
        logic [4:0]  reg_addr;
        logic [15:0] wdata;
    } mgmt_req_s;
endpackage : phy_ctrl_pkg
`default_nettype wire

// ---- src/mdio_serial_port.sv ----
`default_nettype none
module mdio_serial_port (
    input  wire logic                    sys_clk_in,
    input  wire logic                    nrst_in,
    input  wire logic                    mdc_in,
    input  wire logic                    mdio_in,
    input  wire logic [4:0]              phy_addr_in,
    input  wire logic [15:0]             rdata_in,
    output var  logic                    mdio_out,
    output var  logic                    mdio_oe_out,
    output var  logic                    req_valid_out,
    output var  phy_ctrl_pkg::mgmt_req_s req_out
);
    typedef enum logic [2:0] {ST_PRE, ST_START, ST_HDR, ST_TA, ST_DATA} frame_e;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stages feed only the second stages
    // Station address is a pin as well, so it gets the same two stages
    logic       mdc_s1, mdc_s2, mdc_d, mdio_s1, mdio_s2;
    logic [4:0] phy_s1, phy_s2;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {mdc_s1, mdc_s2, mdc_d, mdio_s1, mdio_s2} <= 5'h00;
            phy_s1 <= 5'h00;
            phy_s2 <= 5'h00;
        end else begin
            mdc_s1  <= mdc_in;
            mdc_s2  <= mdc_s1;
            mdc_d   <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
            phy_s1  <= phy_addr_in;
            phy_s2  <= phy_s1;
        end
    end

    // Same sync depth on both pins keeps data aligned to the clock edge
    logic rise;
    assign rise = mdc_s2 & ~mdc_d;

    ////////////////////////////////////////////////////////////////////////
    // Frame state
    frame_e                  state, next_state;
    logic [5:0]              cnt, next_cnt;
    logic [15:0]             shreg, next_shreg;
    logic [11:0]             hdr, next_hdr;
    logic                    is_read, next_is_read;
    logic                    next_mdio, next_oe, next_valid;
    phy_ctrl_pkg::mgmt_req_s next_req;

    // Frame decode; one step per sampled clock rise
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_shreg   = shreg;
        next_hdr     = hdr;
        next_is_read = is_read;
        next_mdio    = mdio_out;
        next_oe      = mdio_oe_out;
        next_valid   = 1'b0;
        next_req     = req_out;
        if (rise) begin
            case (state)
                ST_PRE: begin
                    if (mdio_s2) begin
                        if (cnt < phy_ctrl_pkg::PREAMBLE_LEN) next_cnt = cnt + 6'h01;
                    end else begin
                        if (cnt == phy_ctrl_pkg::PREAMBLE_LEN) next_state = ST_START;
                        next_cnt = 6'h00;
                    end
                end
                ST_START: begin
                    next_state = mdio_s2 ? ST_HDR : ST_PRE;
                    next_cnt   = 6'h00;
                end
                ST_HDR: begin
                    next_hdr = {hdr[10:0], mdio_s2};
                    next_cnt = cnt + 6'h01;
                    if (cnt == phy_ctrl_pkg::HDR_LAST) begin
                        next_cnt   = 6'h00;
                        next_state = ST_PRE;
                        // Frames for another station address are ignored whole
                        if (next_hdr[9:5] == phy_s2 &&
                            (next_hdr[11:10] == phy_ctrl_pkg::OP_READ ||
                             next_hdr[11:10] == phy_ctrl_pkg::OP_WRITE)) begin
                            next_state        = ST_TA;
                            next_is_read      = next_hdr[11:10] == phy_ctrl_pkg::OP_READ;
                            next_req.reg_addr = next_hdr[4:0];
                        end
                    end
                end
                ST_TA: begin
                    next_cnt = cnt + 6'h01;
                    if (cnt == 6'h00) begin
                        next_oe   = is_read;
                        next_mdio = 1'b0;
                    end else begin
                        next_cnt   = 6'h00;
                        next_state = ST_DATA;
                        if (is_read) begin
                            next_mdio  = rdata_in[15];
                            next_shreg = {rdata_in[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    next_cnt = cnt + 6'h01;
                    if (is_read) begin
                        next_mdio  = shreg[15];
                        next_shreg = {shreg[14:0], 1'b0};
                    end else begin
                        next_shreg = {shreg[14:0], mdio_s2};
                    end
                    if (cnt == phy_ctrl_pkg::DATA_LAST) begin
                        next_cnt   = 6'h00;
                        next_state = ST_PRE;
                        next_oe    = 1'b0;
                        next_mdio  = 1'b0;
                        if (!is_read) begin
                            next_valid     = 1'b1;
                            next_req.write = 1'b1;
                            next_req.wdata = {shreg[14:0], mdio_s2};
                        end
                    end
                end
                default: begin
                    next_state = ST_PRE;
                    next_cnt   = 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state         <= ST_PRE;
            cnt           <= 6'h00;
            shreg         <= 16'h0000;
            hdr           <= 12'h000;
            is_read       <= 1'b0;
            mdio_out      <= 1'b0;
            mdio_oe_out   <= 1'b0;
            req_valid_out <= 1'b0;
            req_out       <= '0;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            shreg         <= next_shreg;
            hdr           <= next_hdr;
            is_read       <= next_is_read;
            mdio_out      <= next_mdio;
            mdio_oe_out   <= next_oe;
            req_valid_out <= next_valid;
            req_out       <= next_req;
        end
    end
endmodule : mdio_serial_port
`default_nettype wire

// ---- src/phy_basic_control_upper.sv ----
`default_nettype none
module phy_basic_control_upper (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       mdc_in,
    input  wire logic       mdio_in,
    output var  logic       mdio_out,
    output var  logic       mdio_oe_out,
    input  wire logic [4:0] phy_addr_in,
    input  wire logic       speed_strap_in,
    input  wire logic       autoneg_enable_strap_in,
    input  wire logic       isolate_strap_in,
    input  wire logic       an_speed_100_in,
    input  wire logic       an_full_duplex_in,
    input  wire logic       manual_full_duplex_in,
    output var  logic       loopback_out,
    output var  logic       speed_100_out,
    output var  logic       full_duplex_out,
    output var  logic       autoneg_enable_out,
    output var  logic       power_down_out,
    output var  logic       isolate_out,
    output var  logic       autoneg_restart_out,
    output var  logic       soft_reset_out
);
    ////////////////////////////////////////////////////////////////////////
    // Serial management port
    logic                    req_valid;
    phy_ctrl_pkg::mgmt_req_s req;
    logic [15:0]             rdata;

    mdio_serial_port u_port (
        .sys_clk_in    (sys_clk_in),
        .nrst_in       (nrst_in),
        .mdc_in        (mdc_in),
        .mdio_in       (mdio_in),
        .phy_addr_in   (phy_addr_in),
        .rdata_in      (rdata),
        .mdio_out      (mdio_out),
        .mdio_oe_out   (mdio_oe_out),
        .req_valid_out (req_valid),
        .req_out       (req)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strap pins, two flops each before use
    logic [phy_ctrl_pkg::STRAP_COUNT-1:0] strap_pins, strap_s1, strap_s2;
    assign strap_pins = {isolate_strap_in, autoneg_enable_strap_in, speed_strap_in};

    genvar g;
    generate
        for (g = 0; g < phy_ctrl_pkg::STRAP_COUNT; g++) begin : g_strap
            always_ff @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    strap_s1[g] <= 1'b0;
                    strap_s2[g] <= 1'b0;
                end else begin
                    strap_s1[g] <= strap_pins[g];
                    strap_s2[g] <= strap_s1[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control bits
    logic [1:0] init_cnt, next_init_cnt;
    logic       next_loopback, next_speed_sel, next_an_en, next_pd, next_iso;
    logic       next_restart, next_sreset, next_speed, next_duplex;
    logic       speed_sel;
    logic       wr_ctrl;

    assign wr_ctrl = req_valid && req.write && req.reg_addr == phy_ctrl_pkg::REG_BASIC_CONTROL;

    // Writes only count once the straps have settled and been caught
    always_comb begin
        next_init_cnt = init_cnt;
        next_loopback = loopback_out;
        next_speed_sel = speed_sel;
        next_an_en    = autoneg_enable_out;
        next_pd       = power_down_out;
        next_iso      = isolate_out;
        next_restart  = 1'b0;
        next_sreset   = 1'b0;
        if (init_cnt != phy_ctrl_pkg::STRAP_SETTLE) begin
            next_init_cnt = init_cnt + 2'h1;
            if (next_init_cnt == phy_ctrl_pkg::STRAP_SETTLE) begin
                next_speed_sel = strap_s2[phy_ctrl_pkg::STRAP_SPEED];
                next_an_en     = strap_s2[phy_ctrl_pkg::STRAP_AN];
                next_iso       = strap_s2[phy_ctrl_pkg::STRAP_ISOLATE];
            end
        end else if (wr_ctrl) begin
            if (req.wdata[phy_ctrl_pkg::BIT_SOFT_RESET]) begin
                if (power_down_out) begin
                    // First reset write only leaves power-down
                    next_pd = 1'b0;
                end else begin
                    // Full reset relatches straps, pulse reads back as zero
                    next_sreset    = 1'b1;
                    next_loopback  = phy_ctrl_pkg::RST_LOOPBACK;
                    next_pd        = phy_ctrl_pkg::RST_POWER_DOWN;
                    next_speed_sel = strap_s2[phy_ctrl_pkg::STRAP_SPEED];
                    next_an_en     = strap_s2[phy_ctrl_pkg::STRAP_AN];
                    next_iso       = strap_s2[phy_ctrl_pkg::STRAP_ISOLATE];
                end
            end else begin
                next_loopback  = req.wdata[phy_ctrl_pkg::BIT_LOOPBACK];
                next_speed_sel = req.wdata[phy_ctrl_pkg::BIT_SPEED_SEL];
                next_an_en     = req.wdata[phy_ctrl_pkg::BIT_AN_ENABLE];
                next_pd        = req.wdata[phy_ctrl_pkg::BIT_POWER_DOWN];
                next_iso       = req.wdata[phy_ctrl_pkg::BIT_ISOLATE];
                next_restart   = req.wdata[phy_ctrl_pkg::BIT_AN_RESTART];
            end
        end
        // Negotiated result overrides the manual settings
        next_speed  = autoneg_enable_out ? an_speed_100_in : speed_sel;
        next_duplex = autoneg_enable_out ? an_full_duplex_in : manual_full_duplex_in;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            init_cnt            <= 2'h0;
            loopback_out        <= phy_ctrl_pkg::RST_LOOPBACK;
            speed_sel           <= 1'b0;
            autoneg_enable_out  <= 1'b0;
            power_down_out      <= phy_ctrl_pkg::RST_POWER_DOWN;
            isolate_out         <= 1'b0;
            autoneg_restart_out <= phy_ctrl_pkg::RST_AN_RESTART;
            soft_reset_out      <= phy_ctrl_pkg::RST_SOFT_RESET;
            speed_100_out       <= 1'b0;
            full_duplex_out     <= 1'b0;
        end else begin
            init_cnt            <= next_init_cnt;
            loopback_out        <= next_loopback;
            speed_sel           <= next_speed_sel;
            autoneg_enable_out  <= next_an_en;
            power_down_out      <= next_pd;
            isolate_out         <= next_iso;
            autoneg_restart_out <= next_restart;
            soft_reset_out      <= next_sreset;
            speed_100_out       <= next_speed;
            full_duplex_out     <= next_duplex;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read view; self-clearing bits and unbacked addresses read zero
    always_comb begin
        rdata = 16'h0000;
        if (req.reg_addr == phy_ctrl_pkg::REG_BASIC_CONTROL) begin
            rdata[phy_ctrl_pkg::BIT_LOOPBACK]   = loopback_out;
            rdata[phy_ctrl_pkg::BIT_SPEED_SEL]  = speed_sel;
            rdata[phy_ctrl_pkg::BIT_AN_ENABLE]  = autoneg_enable_out;
            rdata[phy_ctrl_pkg::BIT_POWER_DOWN] = power_down_out;
            rdata[phy_ctrl_pkg::BIT_ISOLATE]    = isolate_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic ready;
    assign ready = init_cnt == phy_ctrl_pkg::STRAP_SETTLE;

    a_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        req.reg_addr != phy_ctrl_pkg::REG_BASIC_CONTROL |-> rdata == 16'h0000)
        else $error("unmapped register read not zero");
    a_reset_pulse: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ready && wr_ctrl && req.wdata[15] && !power_down_out
        |=> soft_reset_out ##1 !soft_reset_out)
        else $error("software reset not a single pulse");
    a_speed_manual: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !autoneg_enable_out |=> speed_100_out == $past(speed_sel))
        else $error("manual speed not followed");
    a_speed_negotiated: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        autoneg_enable_out |=> speed_100_out == $past(an_speed_100_in)
                               && full_duplex_out == $past(an_full_duplex_in))
        else $error("negotiated result not taking precedence");
    a_pd_wake_first: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ready && wr_ctrl && req.wdata[15] && power_down_out
        |=> !power_down_out && !soft_reset_out)
        else $error("first reset write out of power-down misbehaved");
    a_isolate_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ready && wr_ctrl && !req.wdata[15] |=> isolate_out == $past(req.wdata[10])
                                              && autoneg_enable_out == $past(req.wdata[12]))
        else $error("isolate or enable write not stored");
    a_restart_pulse: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ready && wr_ctrl && !req.wdata[15] && req.wdata[9]
        |=> autoneg_restart_out ##1 !autoneg_restart_out)
        else $error("restart not a single pulse");
    a_strap_reload: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        soft_reset_out |-> isolate_out == $past(strap_s2[2]) && !loopback_out
                           && autoneg_enable_out == $past(strap_s2[1]) && !power_down_out)
        else $error("straps not relatched on software reset");
    // Startup latch; loopback and power-down must still read zero then
    a_init_straps: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        init_cnt == phy_ctrl_pkg::STRAP_SETTLE - 2'h1 |=> speed_sel == $past(strap_s2[0])
            && autoneg_enable_out == $past(strap_s2[1]) && isolate_out == $past(strap_s2[2])
            && !loopback_out && !power_down_out)
        else $error("straps not latched after reset");
    a_duplex_manual: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !autoneg_enable_out |=> full_duplex_out == $past(manual_full_duplex_in))
        else $error("manual duplex not followed");
    a_speed_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ready && wr_ctrl && !req.wdata[15] |=> speed_sel == $past(req.wdata[13]))
        else $error("speed select write not stored");
    a_pd_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ready && wr_ctrl && !req.wdata[15] |=> power_down_out == $past(req.wdata[11])
                                              && loopback_out == $past(req.wdata[14]))
        else $error("power-down or loopback write not stored");
endmodule : phy_basic_control_upper
`default_nettype wire

// ---- sim/mac_mgmt_model.sv ----
`default_nettype none
module mac_mgmt_model (
    input  wire logic sys_clk_in,
    input  wire logic mdio_in,
    output var  logic mdc_out,
    output var  logic mdio_out,
    output var  logic mdio_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Management clock stands low between frames
    initial begin
        mdc_out     = 1'b0;
        mdio_out    = 1'b1;
        mdio_oe_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : wait_clk

    // One bit: four clocks low, four high; the line is sampled on the rise
    task automatic send_bit(input logic drive, input logic b, output logic seen);
        @(posedge sys_clk_in);
        mdc_out     <= 1'b0;
        mdio_oe_out <= drive;
        mdio_out    <= b;
        wait_clk(3);
        @(posedge sys_clk_in);
        seen = mdio_in;
        mdc_out <= 1'b1;
        wait_clk(3);
    endtask : send_bit

    // Whole frame; released line reads back the pull-up level
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] rg, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic        s;
        logic [13:0] hdr;
        logic        drv;
        hdr = {2'b01, op, phy, rg};
        drv = (op != phy_ctrl_pkg::OP_READ);
        for (int i = 0; i < 32; i++) send_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) send_bit(1'b1, hdr[i], s);
        send_bit(drv, 1'b1, s);
        send_bit(drv, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            send_bit(drv, wd[i], s);
            rd[i] = s;
        end
        @(posedge sys_clk_in);
        mdc_out     <= 1'b0;
        mdio_oe_out <= 1'b0;
        // Write lands 3-4 clocks after the last rise, outputs one later
        wait_clk(8);
    endtask : frame
endmodule : mac_mgmt_model
`default_nettype wire

// ---- sim/tb_phy_basic_control_upper.sv ----
`default_nettype none
module tb_phy_basic_control_upper;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [4:0] PHY = 5'h05;
    logic        sys_clk, nrst, mdc, mdio_line, dev_mdio, dev_oe, mac_mdio, mac_oe;
    logic        speed_strap, an_strap, iso_strap, an_speed, an_fd, man_fd;
    logic        loop_o, spd_o, fd_o, an_o, pd_o, iso_o, restart_o, srst_o;
    logic [15:0] restart_cnt, srst_cnt, d, b;
    int          miscompares, cmp_count;

    // Pull-up wins when nobody drives the data line
    assign mdio_line = dev_oe ? dev_mdio : (mac_oe ? mac_mdio : 1'b1);

    phy_basic_control_upper phy_basic_control_upper_i (
        .sys_clk_in(sys_clk), .nrst_in(nrst), .mdc_in(mdc), .mdio_in(mdio_line),
        .mdio_out(dev_mdio), .mdio_oe_out(dev_oe), .phy_addr_in(PHY),
        .speed_strap_in(speed_strap), .autoneg_enable_strap_in(an_strap),
        .isolate_strap_in(iso_strap), .an_speed_100_in(an_speed),
        .an_full_duplex_in(an_fd), .manual_full_duplex_in(man_fd),
        .loopback_out(loop_o), .speed_100_out(spd_o), .full_duplex_out(fd_o),
        .autoneg_enable_out(an_o), .power_down_out(pd_o), .isolate_out(iso_o),
        .autoneg_restart_out(restart_o), .soft_reset_out(srst_o));

    mac_mgmt_model mac_mgmt_model_i (
        .sys_clk_in(sys_clk), .mdio_in(mdio_line), .mdc_out(mdc),
        .mdio_out(mac_mdio), .mdio_oe_out(mac_oe));

    always #4 sys_clk = ~sys_clk;

    // Cycles high per pulse; a wide pulse shows up as an extra count
    always @(posedge sys_clk) begin
        if (restart_o === 1'b1) restart_cnt <= restart_cnt + 16'h0001;
        if (srst_o === 1'b1) srst_cnt <= srst_cnt + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk16

    task automatic chk1(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic wr(input logic [4:0] rg, input logic [15:0] wd);
        logic [15:0] r;
        mac_mgmt_model_i.frame(phy_ctrl_pkg::OP_WRITE, PHY, rg, wd, r);
    endtask : wr

    task automatic rdreg(input logic [4:0] rg, output logic [15:0] r);
        mac_mgmt_model_i.frame(phy_ctrl_pkg::OP_READ, PHY, rg, 16'h0000, r);
    endtask : rdreg

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        rdreg(phy_ctrl_pkg::REG_BASIC_CONTROL, d);
        chk16("reg0 default", 16'h2400, d);
        chk1("isolate", 1'b1, iso_o);
        chk1("loopback", 1'b0, loop_o);
        chk1("power down", 1'b0, pd_o);
        $display("test defaults done");
    endtask : t_defaults

    // Negotiated inputs set opposite to manual bits to show they are ignored
    task automatic t_manual;
        @(posedge sys_clk);
        an_speed <= 1'b1;
        an_fd    <= 1'b1;
        wr(5'h00, 16'h0000);
        chk1("speed 10", 1'b0, spd_o);
        chk1("manual duplex", 1'b0, fd_o);
        chk1("isolate off", 1'b0, iso_o);
        wr(5'h00, 16'h2000);
        chk1("speed 100", 1'b1, spd_o);
        rdreg(5'h00, d);
        chk16("reg0 manual", 16'h2000, d);
        $display("test manual done");
    endtask : t_manual

    task automatic t_autoneg;
        wr(5'h00, 16'h1000);
        chk1("autoneg on", 1'b1, an_o);
        chk1("an speed", 1'b1, spd_o);
        chk1("an duplex", 1'b1, fd_o);
        @(posedge sys_clk);
        an_speed <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk1("an speed follow", 1'b0, spd_o);
        $display("test autoneg done");
    endtask : t_autoneg

    task automatic t_restart;
        b = restart_cnt;
        wr(5'h00, 16'h3200);
        chk16("restart pulses", b + 16'h0001, restart_cnt);
        rdreg(5'h00, d);
        chk16("restart self clear", 16'h3000, d);
        $display("test restart done");
    endtask : t_restart

    // Straps change first, so the second reset write must pick them up
    task automatic t_power;
        @(posedge sys_clk);
        speed_strap <= 1'b0;
        an_strap    <= 1'b1;
        iso_strap   <= 1'b0;
        wr(5'h00, 16'h4800);
        chk1("power down on", 1'b1, pd_o);
        b = srst_cnt;
        wr(5'h00, 16'h8000);
        chk1("wake", 1'b0, pd_o);
        chk16("no reset on wake", b, srst_cnt);
        chk1("loopback kept", 1'b1, loop_o);
        wr(5'h00, 16'h8000);
        chk16("reset pulses", b + 16'h0001, srst_cnt);
        chk1("loopback cleared", 1'b0, loop_o);
        rdreg(5'h00, d);
        chk16("reg0 after reset", 16'h1000, d);
        $display("test power down done");
    endtask : t_power

    // Vendor registers 10h and 1Fh, foreign address, bad opcode
    task automatic t_space;
        wr(phy_ctrl_pkg::REG_VENDOR_FIRST, 16'hFFFF);
        rdreg(phy_ctrl_pkg::REG_VENDOR_FIRST, d);
        chk16("reg 10h", 16'h0000, d);
        rdreg(phy_ctrl_pkg::REG_VENDOR_LAST, d);
        chk16("reg 1Fh", 16'h0000, d);
        mac_mgmt_model_i.frame(phy_ctrl_pkg::OP_WRITE, 5'h06, 5'h00, 16'h0000, d);
        mac_mgmt_model_i.frame(2'h3, PHY, 5'h00, 16'h0000, d);
        rdreg(5'h00, d);
        chk16("reg0 untouched", 16'h1000, d);
        $display("test space done");
    endtask : t_space

    ////////////////////////////////////////////////////////////////////////
    // Hang guard; no frame sequence comes near this
    initial begin
        #400000;
        miscompares++;
        $display("unexpected timeout expected done seen hang");
        complete_run;
    end

    initial begin
        sys_clk     = 1'b0;
        nrst        = 1'b0;
        speed_strap = 1'b1;
        an_strap    = 1'b0;
        iso_strap   = 1'b1;
        an_speed    = 1'b0;
        an_fd       = 1'b0;
        man_fd      = 1'b0;
        restart_cnt = 16'h0000;
        srst_cnt    = 16'h0000;
        miscompares = 0;
        cmp_count   = 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        t_defaults;
        t_manual;
        t_autoneg;
        t_restart;
        t_power;
        t_space;
        complete_run;
    end
endmodule : tb_phy_basic_control_upper
`default_nettype wire
